// ### scr_device.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module scr_device #(
    parameter scr_pkg::scr_id_t ID_CODE = 6'h15  // Arbitrary value
) (
    // System
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_b,
    // Calibration results
    input  wire scr_pkg::scr_dac_t i_dac_i,
    input  wire scr_pkg::scr_dac_t i_dac_q,
    // Link
    scr_link_if.dev                link,
    // Register contents
    output scr_pkg::scr_word_t     o_setup_gain_filter,
    output scr_pkg::scr_word_t     o_dc_cal_setup,
    output scr_pkg::scr_word_t     o_load_filter_ctrl,
    output scr_pkg::scr_word_t     o_trim_settings,
    // Load events
    output logic                   o_load_pulse,
    output scr_pkg::scr_addr_t     o_load_addr,
    output logic                   o_rb_active
);

    typedef struct packed {
        logic [2:0]         in_ff1;
        logic [2:0]         in_ff2;
        logic               sclk_prev;
        logic               strb_prev;
        scr_pkg::scr_word_t shift;
        scr_pkg::scr_word_t reg1;
        scr_pkg::scr_word_t reg2;
        scr_pkg::scr_word_t reg3;
        scr_pkg::scr_word_t reg5;
        logic               rb_armed;
        logic               rb_idle_done;
        logic [5:0]         rb_cnt;
        scr_pkg::scr_word_t rb_word;
        logic               rb_out;
        logic               load_pulse;
        scr_pkg::scr_addr_t load_addr;
    } scr_dev_state_t;

    localparam scr_dev_state_t RST_STATE = '{
        in_ff1:       3'h0,
        in_ff2:       3'h0,
        sclk_prev:    1'b0,
        strb_prev:    1'b0,
        shift:        32'h0000_0000,
        reg1:         scr_pkg::RST_REG1,
        reg2:         scr_pkg::RST_REG2,
        reg3:         scr_pkg::RST_REG3,
        reg5:         scr_pkg::RST_REG5,
        rb_armed:     1'b0,
        rb_idle_done: 1'b0,
        rb_cnt:       6'h00,
        rb_word:      32'h0000_0000,
        rb_out:       1'b0,
        load_pulse:   1'b0,
        load_addr:    3'h0
    };

    scr_dev_state_t state_reg;
    scr_dev_state_t state_next;

    logic               sclk_rise;
    logic               strb_rise;
    logic               data_bit;
    scr_pkg::scr_addr_t word_addr;
    scr_pkg::scr_addr_t rb_sel;
    scr_pkg::scr_word_t reg0_word;
    scr_pkg::scr_word_t rb_pick;
    logic               rb_shift_en;
    logic               rb_last_bit;
    logic               load_known;

    // Edge finding on the synchronised link pins
    assign sclk_rise = state_reg.in_ff2[scr_pkg::SYN_SCLK] & ~state_reg.sclk_prev;
    assign strb_rise = state_reg.in_ff2[scr_pkg::SYN_STRB] & ~state_reg.strb_prev;
    assign data_bit  = state_reg.in_ff2[scr_pkg::SYN_DATA];

    // Address from the lowest bits of the collected word
    assign word_addr = state_reg.shift[scr_pkg::ADDR_LSB +: scr_pkg::ADDR_W];
    assign rb_sel    = state_reg.shift[scr_pkg::RB_SEL_LSB +: scr_pkg::ADDR_W];

    // Readback steps only after the idle pulse has passed
    assign rb_shift_en = state_reg.rb_armed & state_reg.rb_idle_done;
    assign rb_last_bit = (state_reg.rb_cnt == scr_pkg::RB_LAST);

    // Only the five defined addresses take a load
    assign load_known  = (word_addr != scr_pkg::ADDR_REG4) &&
                         (word_addr <= scr_pkg::ADDR_REG5);

    // Identity and calibration result word
    always_comb begin
        reg0_word = '0;
        reg0_word[scr_pkg::ADDR_LSB +: scr_pkg::ADDR_W] = scr_pkg::ADDR_REG0;
        reg0_word[scr_pkg::ID_LSB +: scr_pkg::ID_W] = ID_CODE;
        reg0_word[scr_pkg::QDAC_LSB +: scr_pkg::DAC_W] = i_dac_q;
        reg0_word[scr_pkg::IDAC_LSB +: scr_pkg::DAC_W] = i_dac_i;
    end

    // Source of the readback word
    always_comb begin
        unique case (rb_sel)
            scr_pkg::ADDR_REG0: rb_pick = reg0_word;
            scr_pkg::ADDR_REG1: rb_pick = state_reg.reg1;
            scr_pkg::ADDR_REG2: rb_pick = state_reg.reg2;
            scr_pkg::ADDR_REG3: rb_pick = state_reg.reg3;
            scr_pkg::ADDR_REG5: rb_pick = state_reg.reg5;
            default:            rb_pick = '0;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        state_next.load_pulse = 1'b0;

        // Two-flop synchronisers
        state_next.in_ff1[scr_pkg::SYN_SCLK] = link.sclk;
        state_next.in_ff1[scr_pkg::SYN_DATA] = link.sdata;
        state_next.in_ff1[scr_pkg::SYN_STRB] = link.load_strobe;
        state_next.in_ff2    = state_reg.in_ff1;
        state_next.sclk_prev = state_reg.in_ff2[scr_pkg::SYN_SCLK];
        state_next.strb_prev = state_reg.in_ff2[scr_pkg::SYN_STRB];

        if (sclk_rise) begin
            // New bit enters at the top, so the first bit sent lands in bit zero
            state_next.shift = {data_bit, state_reg.shift[scr_pkg::WORD_W-1:1]};
            // Readback pin moves only on a serial clock rise
            if (!state_reg.rb_armed) begin
                state_next.rb_out = 1'b0;
            end else if (!rb_shift_en) begin
                state_next.rb_idle_done = 1'b1;
            end else begin
                state_next.rb_out  = state_reg.rb_word[0];
                state_next.rb_word = state_reg.rb_word >> 1;
                state_next.rb_cnt  = state_reg.rb_cnt + 6'h01;
                if (rb_last_bit) begin
                    state_next.rb_armed = 1'b0;
                end
            end
        end

        if (strb_rise) begin
            // Any load ends a readback still in progress
            state_next.rb_armed     = 1'b0;
            state_next.rb_idle_done = 1'b0;
            state_next.rb_cnt       = '0;
            state_next.load_addr    = word_addr;
            state_next.load_pulse   = load_known;
            // Whole word stored, address bits included
            unique case (word_addr)
                scr_pkg::ADDR_REG0: begin
                    if (state_reg.shift[scr_pkg::RB_EN_BIT]) begin
                        state_next.rb_armed = 1'b1;
                        state_next.rb_word  = rb_pick;
                    end
                end
                scr_pkg::ADDR_REG1: begin
                    state_next.reg1 = state_reg.shift;
                end
                scr_pkg::ADDR_REG2: begin
                    state_next.reg2 = state_reg.shift;
                end
                scr_pkg::ADDR_REG3: begin
                    state_next.reg3 = state_reg.shift;
                end
                scr_pkg::ADDR_REG5: begin
                    state_next.reg5 = state_reg.shift;
                end
                default: begin
                    state_next.load_pulse = 1'b0;
                end
            endcase
        end
    end

    // One register stage holds the whole state
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= RST_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs
    assign link.readback         = state_reg.rb_out;
    assign o_setup_gain_filter   = state_reg.reg1;
    assign o_dc_cal_setup        = state_reg.reg2;
    assign o_load_filter_ctrl    = state_reg.reg3;
    assign o_trim_settings       = state_reg.reg5;
    assign o_load_pulse          = state_reg.load_pulse;
    assign o_load_addr           = state_reg.load_addr;
    assign o_rb_active           = state_reg.rb_armed;

endmodule // scr_device

// ### scr_pkg.sv
package scr_pkg;

    // Word and address field
    localparam int WORD_W   = 32;
    localparam int ADDR_W   = 3;
    localparam int ADDR_LSB = 0;
    typedef logic [WORD_W-1:0] scr_word_t;
    typedef logic [ADDR_W-1:0] scr_addr_t;

    // Register addresses
    localparam scr_addr_t ADDR_REG0 = 3'h0;
    localparam scr_addr_t ADDR_REG1 = 3'h1;
    localparam scr_addr_t ADDR_REG2 = 3'h2;
    localparam scr_addr_t ADDR_REG3 = 3'h3;
    localparam scr_addr_t ADDR_REG4 = 3'h4;
    localparam scr_addr_t ADDR_REG5 = 3'h5;

    // Reset contents
    localparam scr_word_t RST_REG1 = 32'h0100_fc89;
    localparam scr_word_t RST_REG2 = 32'h0000_000a;
    localparam scr_word_t RST_REG3 = 32'h0000_000b;
    localparam scr_word_t RST_REG5 = 32'h0000_000d;

    // Readback command, written to address zero
    localparam int RB_EN_BIT  = 31;
    localparam int RB_SEL_LSB = 5;

    // Identity and calibration word layout
    localparam int ID_W     = 6;
    localparam int ID_LSB   = 5;
    localparam int DAC_W    = 10;
    localparam int QDAC_LSB = 12;
    localparam int IDAC_LSB = 22;
    typedef logic [ID_W-1:0]  scr_id_t;
    typedef logic [DAC_W-1:0] scr_dac_t;

    // Synchroniser lanes
    localparam int SYN_SCLK = 0;
    localparam int SYN_DATA = 1;
    localparam int SYN_STRB = 2;

    // Readback sequence
    localparam int        CNT_W   = 6;
    localparam logic [5:0] RB_LAST = 6'h1f;
    localparam logic [5:0] RD_LAST = 6'h20;
    localparam logic [5:0] WR_LAST = 6'h1f;

    // Serial clock timing, host side
    localparam int        CLK_NS      = 100;
    localparam int        SCLK_HALF_NS = 800;
    localparam int        HALF_CYC    = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] HALF_LAST  = 4'(HALF_CYC - 1);

    // Host command port map
    localparam logic [3:0] H_OFF_TX   = 4'h0;
    localparam logic [3:0] H_OFF_CTRL = 4'h4;
    localparam logic [3:0] H_OFF_STAT = 4'h8;
    localparam logic [3:0] H_OFF_RX   = 4'hc;
    localparam int CTRL_GO_WR  = 0;
    localparam int CTRL_GO_RD  = 1;
    localparam int CTRL_SEL_LSB = 2;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_DONE   = 1;

endpackage

// ### scr_link_if.sv
`timescale 1ns/1ns
interface scr_link_if;
    logic sclk;
    logic sdata;
    logic load_strobe;
    logic readback;

    modport dev (
        input  sclk,
        input  sdata,
        input  load_strobe,
        output readback
    );

    modport host (
        output sclk,
        output sdata,
        output load_strobe,
        input  readback
    );
endinterface

// ### scr_host.sv
`timescale 1ns/1ns
module scr_host (
    // System
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst_b,
    // Command port
    input  wire logic [3:0]         i_addr,
    input  wire scr_pkg::scr_word_t i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output scr_pkg::scr_word_t      o_rdata,
    output logic                    o_busy,
    // Link
    scr_link_if.host                link
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_STRB,
        ST_READ
    } scr_host_st_t;

    typedef struct packed {
        scr_host_st_t       st;
        logic [3:0]         div;
        logic               sclk;
        logic               sdata;
        logic               strobe;
        logic [5:0]         bitn;
        scr_pkg::scr_word_t tx;
        scr_pkg::scr_word_t txbuf;
        scr_pkg::scr_word_t rx;
        logic               rb_mode;
        logic               rb_ff1;
        logic               rb_ff2;
        logic               done;
        scr_pkg::scr_word_t rdata;
    } scr_host_state_t;

    scr_host_state_t state_reg;
    scr_host_state_t state_next;
    logic            tick;
    scr_pkg::scr_word_t cmd;

    assign tick = (state_reg.div == scr_pkg::HALF_LAST);

    // Readback command: address zero, enable bit, register select
    always_comb begin
        cmd = '0;
        cmd[scr_pkg::ADDR_LSB +: scr_pkg::ADDR_W] = scr_pkg::ADDR_REG0;
        cmd[scr_pkg::RB_EN_BIT] = 1'b1;
        cmd[scr_pkg::RB_SEL_LSB +: scr_pkg::ADDR_W] =
            i_wdata[scr_pkg::CTRL_SEL_LSB +: scr_pkg::ADDR_W];
    end

    always_comb begin
        state_next = state_reg;
        state_next.rb_ff1 = link.readback;
        state_next.rb_ff2 = state_reg.rb_ff1;
        state_next.rdata  = '0;
        state_next.div    = tick ? 4'h0 : state_reg.div + 4'h1;

        if (i_rd) begin
            unique case (i_addr)
                scr_pkg::H_OFF_TX:   state_next.rdata = state_reg.txbuf;
                scr_pkg::H_OFF_STAT: begin
                    state_next.rdata[scr_pkg::STAT_BUSY] = (state_reg.st != ST_IDLE);
                    state_next.rdata[scr_pkg::STAT_DONE] = state_reg.done;
                end
                scr_pkg::H_OFF_RX:   state_next.rdata = state_reg.rx;
                default:             state_next.rdata = '0;
            endcase
        end

        if (i_wr && i_addr == scr_pkg::H_OFF_TX) begin
            state_next.txbuf = i_wdata;
        end

        unique case (state_reg.st)
            ST_IDLE: begin
                if (i_wr && i_addr == scr_pkg::H_OFF_CTRL &&
                    (i_wdata[scr_pkg::CTRL_GO_RD] || i_wdata[scr_pkg::CTRL_GO_WR])) begin
                    state_next.rb_mode = i_wdata[scr_pkg::CTRL_GO_RD];
                    state_next.tx    = i_wdata[scr_pkg::CTRL_GO_RD] ? cmd : state_reg.txbuf;
                    state_next.sdata = i_wdata[scr_pkg::CTRL_GO_RD] ? cmd[0] : state_reg.txbuf[0];
                    state_next.done  = 1'b0;
                    state_next.bitn  = '0;
                    state_next.div   = '0;
                    state_next.st    = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (tick) begin
                    state_next.sclk = ~state_reg.sclk;
                    if (state_reg.sclk) begin
                        // Next bit set up while the clock is low
                        state_next.tx    = state_reg.tx >> 1;
                        state_next.sdata = state_reg.tx[1];
                        state_next.bitn  = state_reg.bitn + 6'h01;
                        if (state_reg.bitn == scr_pkg::WR_LAST) begin
                            state_next.sdata = 1'b0;
                            state_next.st    = ST_STRB;
                        end
                    end
                end
            end
            ST_STRB: begin
                if (tick) begin
                    state_next.strobe = ~state_reg.strobe;
                    if (state_reg.strobe) begin
                        state_next.bitn = '0;
                        state_next.st   = state_reg.rb_mode ? ST_READ : ST_IDLE;
                        state_next.done = ~state_reg.rb_mode;
                    end
                end
            end
            ST_READ: begin
                if (tick) begin
                    state_next.sclk = ~state_reg.sclk;
                    if (state_reg.sclk) begin
                        // Pulse zero is the idle clock
                        if (state_reg.bitn != '0) begin
                            state_next.rx = {state_reg.rb_ff2,
                                             state_reg.rx[scr_pkg::WORD_W-1:1]};
                        end
                        state_next.bitn = state_reg.bitn + 6'h01;
                        if (state_reg.bitn == scr_pkg::RD_LAST) begin
                            state_next.st   = ST_IDLE;
                            state_next.done = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= '{st: ST_IDLE, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.sclk        = state_reg.sclk;
    assign link.sdata       = state_reg.sdata;
    assign link.load_strobe = state_reg.strobe;
    assign o_rdata          = state_reg.rdata;
    assign o_busy           = (state_reg.st != ST_IDLE);

endmodule // scr_host

// ### scr_link_asserts.sv
`timescale 1ns/1ns
module scr_link_asserts (
    // System
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Link
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic readback
);
    logic       sclk_q;
    logic       stb_q;
    logic       sclk_rise;
    logic       stb_rise;
    logic [3:0] rise_sr;
    logic [6:0] rise_cnt;

    assign sclk_rise = sclk & ~sclk_q;
    assign stb_rise  = load_strobe & ~stb_q;

    // Edge history and clock rises since the last strobe
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_q   <= 1'b0;
            stb_q    <= 1'b0;
            rise_sr  <= 4'h0;
            rise_cnt <= 7'h00;
        end else begin
            sclk_q  <= sclk;
            stb_q   <= load_strobe;
            rise_sr <= {rise_sr[2:0], sclk_rise};
            if (stb_rise) begin
                rise_cnt <= 7'h00;
            end else if (sclk_rise && rise_cnt != 7'h7f) begin
                rise_cnt <= rise_cnt + 7'h01;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    sequence clk_high_s;
        sclk[*8] ##1 !sclk;
    endsequence

    sequence stb_high_s;
        load_strobe[*8] ##1 !load_strobe;
    endsequence

    sclk_high_a: assert property ($rose(sclk) |-> clk_high_s)
        else $error("serial clock high time wrong");
    sclk_low_a: assert property ($fell(sclk) |-> (!sclk)[*8])
        else $error("serial clock low time too short");
    strobe_width_a: assert property ($rose(load_strobe) |-> stb_high_s)
        else $error("load strobe width wrong");
    strobe_clk_low_a: assert property (load_strobe |-> !sclk)
        else $error("serial clock high during load strobe");
    data_setup_a: assert property ($rose(sclk) |-> $stable(sdata) && sdata == $past(sdata, 2))
        else $error("serial data moved before clock rise");
    data_hold_a: assert property (sclk |-> $stable(sdata))
        else $error("serial data moved while clock high");
    frame_count_a: assert property (stb_rise |-> rise_cnt == 7'h20 || rise_cnt == 7'h41)
        else $error("wrong number of clock rises before strobe");
    rb_timing_a: assert property ($changed(readback) |-> |rise_sr)
        else $error("readback changed away from a clock rise");
    rb_window_a: assert property (readback |-> rise_cnt inside {[7'h02:7'h22]})
        else $error("readback driven outside its window");
endmodule // scr_link_asserts

// ### serial_config_readback_port_test.sv
`timescale 1ns/1ns
module serial_config_readback_port_test;
    localparam scr_pkg::scr_id_t TEST_ID = 6'h2c;  // Arbitrary value
    localparam scr_pkg::scr_addr_t REG_ADDR [4] = '{scr_pkg::ADDR_REG1, scr_pkg::ADDR_REG2,
                                                   scr_pkg::ADDR_REG3, scr_pkg::ADDR_REG5};
    logic               i_clk_sys;
    logic               i_rst_b;
    logic [3:0]         i_addr;
    scr_pkg::scr_word_t i_wdata;
    logic               i_wr;
    logic               i_rd;
    scr_pkg::scr_word_t o_rdata;
    logic               o_busy;
    scr_pkg::scr_dac_t  i_dac_i;
    scr_pkg::scr_dac_t  i_dac_q;
    scr_pkg::scr_word_t dev_reg [4];
    scr_pkg::scr_word_t shadow [4];
    logic               load_pulse;
    scr_pkg::scr_addr_t load_addr;
    logic               rb_active;
    scr_pkg::scr_word_t wire_tx;
    scr_pkg::scr_word_t wire_rx;
    scr_pkg::scr_word_t w;
    scr_pkg::scr_word_t d;
    scr_pkg::scr_word_t exp_w;
    int                 loads;
    int                 err_total;
    int                 samples_checked;

    scr_link_if scr_link_if_i ();

    scr_device #(.ID_CODE(TEST_ID)) scr_device_i (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_dac_i(i_dac_i), .i_dac_q(i_dac_q),
        .link(scr_link_if_i.dev), .o_setup_gain_filter(dev_reg[0]), .o_dc_cal_setup(dev_reg[1]),
        .o_load_filter_ctrl(dev_reg[2]), .o_trim_settings(dev_reg[3]),
        .o_load_pulse(load_pulse), .o_load_addr(load_addr), .o_rb_active(rb_active));

    scr_host scr_host_i (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy), .link(scr_link_if_i.host));

    scr_link_asserts scr_link_asserts_i (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .sclk(scr_link_if_i.sclk),
        .sdata(scr_link_if_i.sdata), .load_strobe(scr_link_if_i.load_strobe),
        .readback(scr_link_if_i.readback));

    initial i_clk_sys = 1'b0;
    always #50 i_clk_sys = ~i_clk_sys;

    // Wire-level views of both directions
    always @(posedge scr_link_if_i.sclk) wire_tx <= {scr_link_if_i.sdata, wire_tx[31:1]};
    always @(negedge scr_link_if_i.sclk) wire_rx <= {scr_link_if_i.readback, wire_rx[31:1]};
    always @(posedge i_clk_sys) if (load_pulse === 1'b1) loads <= loads + 1;

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input scr_pkg::scr_word_t seen, input scr_pkg::scr_word_t exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check_regs();
        for (int j = 0; j < 4; j++) begin
            check(dev_reg[j], shadow[j]);
        end
    endtask

    task automatic wr(input logic [3:0] a, input scr_pkg::scr_word_t dat);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= dat;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output scr_pkg::scr_word_t dat);
        @(posedge i_clk_sys);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        dat = o_rdata;
    endtask

    // Start a transfer and poll status until done
    task automatic run(input scr_pkg::scr_word_t ctrl);
        scr_pkg::scr_word_t st;
        int                 n;
        wr(scr_pkg::H_OFF_CTRL, ctrl);
        #1;
        check(32'(o_busy), 32'h0000_0001);
        st = '0;
        n  = 0;
        while (st[scr_pkg::STAT_DONE] !== 1'b1 && n < 2000) begin
            rd(scr_pkg::H_OFF_STAT, st);
            n++;
        end
        check(st & 32'h0000_0003, 32'h0000_0002);
    endtask

    initial begin
        i_rst_b         = 1'b0;
        i_addr          = 4'h0;
        i_wdata         = '0;
        i_wr            = 1'b0;
        i_rd            = 1'b0;
        i_dac_i         = 10'h2b5;
        i_dac_q         = 10'h14a;
        loads           = 0;
        err_total       = 0;
        samples_checked = 0;
        shadow = '{scr_pkg::RST_REG1, scr_pkg::RST_REG2, scr_pkg::RST_REG3, scr_pkg::RST_REG5};
        repeat (10) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        check_regs();
        // Program every implemented register
        for (int k = 0; k < 4; k++) begin
            w = {8'h5a + 8'(k), 8'hc3, 8'h96, 5'(k + 3), REG_ADDR[k]};
            shadow[k] = w;
            wr(scr_pkg::H_OFF_TX, w);
            run(32'h0000_0001);
            check(wire_tx, w);
            check(32'(load_addr), 32'(REG_ADDR[k]));
            check_regs();
        end
        check(32'(loads), 32'h0000_0004);
        // Word to the unused address
        wr(scr_pkg::H_OFF_TX, 32'hffff_fff4);
        run(32'h0000_0001);
        check(wire_tx, 32'hffff_fff4);
        check_regs();
        check(32'(loads), 32'h0000_0004);
        // Read back select values 0 to 5, the unused address 4 included
        for (int k = 0; k < 6; k++) begin
            case (k)
                0: exp_w = (32'(i_dac_i) << scr_pkg::IDAC_LSB) | (32'(i_dac_q) << scr_pkg::QDAC_LSB)
                         | (32'(TEST_ID) << scr_pkg::ID_LSB);
                4: exp_w = 32'h0000_0000;
                5: exp_w = shadow[3];
                default: exp_w = shadow[k - 1];
            endcase
            run(32'h0000_0002 | (32'(k) << scr_pkg::CTRL_SEL_LSB));
            rd(scr_pkg::H_OFF_RX, d);
            check(d, exp_w);
            check(wire_rx, exp_w);
            check(32'(rb_active), 32'h0000_0000);
        end
        check_regs();
        rd(4'h2, d);
        check(d, 32'h0000_0000);
        final_report();
    end

    // About five times the expected run length
    initial begin
        #5_000_000;
        err_total++;
        final_report();
    end
endmodule // serial_config_readback_port_test
